// ### hw/vso_config_bank.sv
// Regulator configuration bank: slew select, transition offsets, sense
// resistor select, negative-current on-time select and the write lock.
// Assumes the serial engine and VID decoder share this clock and give
// one-cycle strobes with address and data valid alongside.
`timescale 1ns/10ps

// Contract
// R1: 5 mV step: on-time numerator 0.6 V when select is 1, else 1.6 V.
// R2: 10 mV step: on-time numerators 1.2 V shorter and 3.2 V longer.
// R3: Fast slew select sets fast-command rate only, not turn-on or off; the code also times soft ramps and other commands from it.
// R4: Acked write to slew select copies it at once to VID rate register.
// R5: Slew codes map to 1.34..12.50 mV/us, doubled for 10 mV step.
// R6: Transition offsets apply only for Fast or Slow slew commands.
// R7: No offsets for Decay commands or serial output-voltage changes.
// R8: No offsets during soft-start or soft-stop.
// R9: Down ramp at selected rate to target plus offset, then quarter rate.
// R10: Down offset codes give 0, 5, 10, 20 mV above target.
// R11: Up offset added as first step, dropped when target reached.
// R12: Up offset codes 00, 10, 11 give 0, 10, 20 mV; 01 undefined.
// R13: After power-on writable registers are locked; writes get NACK.
// R14: Every read is acknowledged with the register byte.
// R15: Full passcode sequence in order on key register unlocks writes.
// R16: Any key write while unlocked relocks; full sequence needed again.
// R17: Power cycle returns the lock to protected.
// R18: Restore-defaults command leaves the lock state unchanged.
// R19: Every key register write answers NACK.
// R20: Fault clear, status and key registers bypass the lock.
// R21: Bus address register bypasses lock except top bit, always protected.
// R22: Reserved upper bits of slew, offset, sense registers read zero.
// R23: Three-bit field selects input sense resistor 0.25 to 4 milliohm.
// R24: Passcode byte sequence comes from a design parameter.
// R25: Sense codes map to resistor, gain and full-scale current table.
module vso_config_bank #(
  parameter int          PASS_LEN = 2,
  parameter logic [15:0] PASSCODE = 16'h3cc3
) (
  input  wire logic                 clock,
  input  wire logic                 arst_n,
  input  wire logic                 cmdWrStb,
  input  wire logic                 cmdRdStb,
  input  wire logic [7:0]           cmdAddr,
  input  wire logic [7:0]           cmdWrData,
  input  wire logic                 restoreDefaults,
  input  wire logic [1:0]           vidStepProtocol,
  input  wire logic                 vidCmdStb,
  input  wire vso_pkg::vso_cmd_e    vidCmdKind,
  input  wire logic [11:0]          vidTargetMv,
  input  wire logic                 softRampActive,
  output logic                      ansValid,
  output logic                      ansAck,
  output logic [7:0]                ansRdData,
  output logic                      writeUnlocked,
  output logic [2:0]                vidFastRateReg,
  output logic [15:0]               fastRateCenti,
  output logic [11:0]               negCurrentOnTimeMv,
  output logic [11:0]               senseResMicroOhm,
  output logic [8:0]                senseGainX10,
  output logic [9:0]                senseIinMaxX10,
  output logic [11:0]               dacMv,
  output logic                      rampBusy
);
  localparam int IDX_W = 4;

  vso_ramp_if rif ();

  logic [2:0]       fastSel_reg;
  logic [3:0]       transOfs_reg;
  logic [2:0]       senseSel_reg;
  logic             nocTon_reg;
  logic [6:0]       busAddr_reg;
  logic             unlocked_reg;
  logic [IDX_W-1:0] keyIdx_reg;

  // Address decode
  wire logic isKey    = (cmdAddr == vso_pkg::ADDR_KEY);
  wire logic isStatus = (cmdAddr >= vso_pkg::ADDR_STAT_LO) && (cmdAddr <= vso_pkg::ADDR_STAT_HI);
  wire logic isExempt = (cmdAddr == vso_pkg::ADDR_FAULT_CLR) || isStatus
                        || (cmdAddr == vso_pkg::ADDR_STAT_MFR)
                        || (cmdAddr == vso_pkg::ADDR_BUS_ADDR); // R20 R21
  wire logic wrAckNow = !isKey && (isExempt || unlocked_reg); // R13 R19 R20
  wire logic wrDo     = cmdWrStb && wrAckNow;
  wire logic keyWr    = cmdWrStb && isKey;

  wire logic wrFast   = wrDo && (cmdAddr == vso_pkg::ADDR_FAST_SLEW);
  wire logic wrOfs    = wrDo && (cmdAddr == vso_pkg::ADDR_TRANS_OFS);
  wire logic wrSense  = wrDo && (cmdAddr == vso_pkg::ADDR_SENSE);
  wire logic wrLoop   = wrDo && (cmdAddr == vso_pkg::ADDR_LOOP_CFG);
  wire logic wrBus    = wrDo && (cmdAddr == vso_pkg::ADDR_BUS_ADDR);

  // Passcode matching; the first byte of the sequence sits in the top bits
  wire logic [7:0] expectByte = PASSCODE[(PASS_LEN - 1 - int'(keyIdx_reg)) * 8 +: 8]; // R24
  wire logic       keyMatch   = (cmdWrData == expectByte);
  wire logic       keyLast    = (keyIdx_reg == IDX_W'(PASS_LEN - 1));

  // Protocols 01 and 10 use the 5 mV step
  wire logic step5 = (vidStepProtocol == 2'b01) || (vidStepProtocol == 2'b10);

  // Read-back with reserved bits forced to zero
  wire logic [7:0] rdMux =
      (cmdAddr == vso_pkg::ADDR_FAST_SLEW) ? {5'h00, fastSel_reg} : // R22
      (cmdAddr == vso_pkg::ADDR_TRANS_OFS) ? {4'h0, transOfs_reg} : // R22
      (cmdAddr == vso_pkg::ADDR_SENSE)     ? {5'h00, senseSel_reg} : // R22
      (cmdAddr == vso_pkg::ADDR_LOOP_CFG)  ? (8'(nocTon_reg) << vso_pkg::NOC_TON_BIT) :
      (cmdAddr == vso_pkg::ADDR_BUS_ADDR)  ? {1'b0, busAddr_reg} : // R21
      (cmdAddr == vso_pkg::ADDR_KEY)       ? vso_pkg::KEY_READBACK :
                                             8'h00;

  // On-time numerator
  wire logic [11:0] tonShort = step5 ? vso_pkg::TON_SHORT_5MV : vso_pkg::TON_SHORT_10MV; // R1 R2
  wire logic [11:0] tonLong  = step5 ? vso_pkg::TON_LONG_5MV : vso_pkg::TON_LONG_10MV; // R1 R2
  wire logic [11:0] tonNext  = nocTon_reg ? tonShort : tonLong;

  // Fast rate for the VID side
  wire logic [15:0] rate5    = vso_pkg::RATE_5MV_CENTI[vidFastRateReg];
  wire logic [15:0] rateNext = step5 ? rate5
                                     : vso_pkg::RATE_10MV_CENTI[vidFastRateReg]; // R5

  // Ramp request
  wire logic isFast    = (vidCmdKind == vso_pkg::CMD_FAST);
  wire logic isSlow    = (vidCmdKind == vso_pkg::CMD_SLOW);
  wire logic ofsAllow  = (isFast || isSlow) && !softRampActive; // R6 R7 R8
  wire logic [11:0] fastPer = vso_pkg::SLEW_PERIOD[vidFastRateReg];
  // Only fast commands use the programmed rate; others ramp at a quarter
  wire logic [11:0] cmdPer  = isFast ? fastPer
                                     : 12'(fastPer << vso_pkg::QUARTER_SHIFT); // R3

  assign rif.start     = vidCmdStb;
  assign rif.targetMv  = vidTargetMv;
  assign rif.stepMv    = step5 ? vso_pkg::STEP_5MV : vso_pkg::STEP_10MV;
  assign rif.periodCyc = cmdPer;
  assign rif.upOfsMv   = vso_pkg::OFS_UP_MV[transOfs_reg[vso_pkg::OFS_UP_LSB +: 2]]; // R12
  assign rif.downOfsMv = vso_pkg::OFS_DOWN_MV[transOfs_reg[vso_pkg::OFS_DOWN_LSB +: 2]]; // R10
  assign rif.ofsEnable = ofsAllow;

  vso_dac_ramp u_ramp (
    .clock  (clock),
    .arst_n (arst_n),
    .rif    (rif.eng)
  );

  // Configuration registers; restore reloads defaults but not the lock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fastSel_reg  <= vso_pkg::RST_FAST_SLEW;
      transOfs_reg <= vso_pkg::RST_TRANS_OFS;
      senseSel_reg <= vso_pkg::RST_SENSE;
      nocTon_reg   <= vso_pkg::RST_NOC_TON;
      busAddr_reg  <= vso_pkg::RST_BUS_ADDR;
    end else if (restoreDefaults) begin
      fastSel_reg  <= vso_pkg::RST_FAST_SLEW;
      transOfs_reg <= vso_pkg::RST_TRANS_OFS;
      senseSel_reg <= vso_pkg::RST_SENSE;
      nocTon_reg   <= vso_pkg::RST_NOC_TON;
      busAddr_reg  <= vso_pkg::RST_BUS_ADDR;
    end else begin
      if (wrFast)  fastSel_reg  <= cmdWrData[2:0];
      if (wrOfs)   transOfs_reg <= cmdWrData[3:0];
      if (wrSense) senseSel_reg <= cmdWrData[2:0]; // R23
      if (wrLoop)  nocTon_reg   <= cmdWrData[vso_pkg::NOC_TON_BIT];
      // Top bit is never stored, so it stays protected whatever the lock
      if (wrBus)   busAddr_reg  <= cmdWrData[6:0]; // R21
    end
  end

  // VID-side fast rate follows each acknowledged slew write at once
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vidFastRateReg <= vso_pkg::RST_FAST_SLEW;
    end else if (restoreDefaults) begin
      vidFastRateReg <= vso_pkg::RST_FAST_SLEW;
    end else if (wrFast) begin
      vidFastRateReg <= cmdWrData[2:0]; // R4
    end
  end

  // Write lock; power-on reset or a key write while unlocked clears it, restore does not
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      unlocked_reg <= 1'b0; // R13 R17
      keyIdx_reg   <= '0;
    end else if (keyWr) begin // R18
      if (unlocked_reg) begin
        unlocked_reg <= 1'b0; // R16
        keyIdx_reg   <= '0;
      end else if (keyMatch && keyLast) begin
        unlocked_reg <= 1'b1; // R15
        keyIdx_reg   <= '0;
      end else if (keyMatch) begin
        keyIdx_reg   <= keyIdx_reg + IDX_W'(1); // R15
      end else begin
        keyIdx_reg   <= '0;
      end
    end
  end

  // Answer one cycle after each strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ansValid  <= 1'b0;
      ansAck    <= 1'b0;
      ansRdData <= 8'h00;
    end else begin
      ansValid  <= cmdWrStb || cmdRdStb;
      ansAck    <= cmdRdStb || wrAckNow; // R14 R19
      ansRdData <= cmdRdStb ? rdMux : 8'h00; // R14
    end
  end

  // Registered status and lookups
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      writeUnlocked      <= 1'b0;
      fastRateCenti      <= 16'h0000;
      negCurrentOnTimeMv <= 12'h000;
      senseResMicroOhm   <= 12'h000;
      senseGainX10       <= 9'h000;
      senseIinMaxX10     <= 10'h000;
      dacMv              <= 12'h000;
      rampBusy           <= 1'b0;
    end else begin
      writeUnlocked      <= unlocked_reg;
      fastRateCenti      <= rateNext; // R5
      negCurrentOnTimeMv <= tonNext; // R1 R2
      senseResMicroOhm   <= vso_pkg::SENSE_RES_UOHM[senseSel_reg]; // R25
      senseGainX10       <= vso_pkg::SENSE_GAIN_X10[senseSel_reg]; // R25
      senseIinMaxX10     <= vso_pkg::SENSE_IMAX_X10[senseSel_reg]; // R25
      dacMv              <= rif.dacMv;
      rampBusy           <= rif.busy;
    end
  end

  key_always_nack_a: assert property (@(posedge clock) disable iff (!arst_n) // R19
    (cmdWrStb && isKey) |=> (ansValid && !ansAck))
    else $error("Key register write was acknowledged");

  locked_write_nack_a: assert property (@(posedge clock) disable iff (!arst_n) // R13
    (cmdWrStb && !unlocked_reg && (cmdAddr == vso_pkg::ADDR_TRANS_OFS))
      |=> (!ansAck && $stable(transOfs_reg)))
    else $error("Locked write reached a gated register");

  read_always_ack_a: assert property (@(posedge clock) disable iff (!arst_n) // R14
    (cmdRdStb && !cmdWrStb) |=> (ansValid && ansAck))
    else $error("Read was not acknowledged");

  relock_on_key_a: assert property (@(posedge clock) disable iff (!arst_n) // R16
    (keyWr && unlocked_reg) |=> (!unlocked_reg ##1 !writeUnlocked))
    else $error("Key write while unlocked did not relock");

  rate_copy_now_a: assert property (@(posedge clock) disable iff (!arst_n) // R4
    (wrFast && !restoreDefaults) |=> (vidFastRateReg == $past(cmdWrData[2:0])))
    else $error("Fast rate copy missed an acknowledged write");

  reserved_zero_a: assert property (@(posedge clock) disable iff (!arst_n) // R22
    (cmdRdStb && (cmdAddr == vso_pkg::ADDR_SENSE || cmdAddr == vso_pkg::ADDR_FAST_SLEW))
      |=> (ansRdData[7:3] == 5'h00))
    else $error("Reserved bits read non-zero");

  no_ofs_soft_a: assert property (@(posedge clock) disable iff (!arst_n) // R8
    (vidCmdStb && (softRampActive || vidCmdKind == vso_pkg::CMD_DECAY
                   || vidCmdKind == vso_pkg::CMD_VOUT_I2C))
      |=> (rif.dacMv == $past(rif.dacMv)))
    else $error("Offsets enabled during soft ramp or decay");

  restore_keeps_lock_a: assert property (@(posedge clock) disable iff (!arst_n) // R18
    (restoreDefaults && !keyWr) |=> (unlocked_reg == $past(unlocked_reg)))
    else $error("Restore changed the lock state");

  cv_unlock: cover property (@(posedge clock) disable iff (!arst_n)
    !unlocked_reg ##1 unlocked_reg);
  cv_gated_write_ack: cover property (@(posedge clock) disable iff (!arst_n)
    wrFast ##1 ansAck);
  cv_fast_down_ofs: cover property (@(posedge clock) disable iff (!arst_n)
    vidCmdStb && isFast && rif.ofsEnable && (vidTargetMv < rif.dacMv));
endmodule : vso_config_bank

// ### hw/vso_pkg.sv
// Constants for the regulator configuration bank: command codes, fields,
// defaults, slew and sense tables.
// Assumes a 100 MHz core clock; values in mV, centi-mV/us, micro-ohm, clock cycles or tenths (x10).
package vso_pkg;

  // Command codes of the serial configuration port
  localparam logic [7:0] ADDR_FAULT_CLR = 8'h03;
  localparam logic [7:0] ADDR_STAT_LO   = 8'h7a;
  localparam logic [7:0] ADDR_STAT_HI   = 8'h7d;
  localparam logic [7:0] ADDR_STAT_MFR  = 8'h80;
  localparam logic [7:0] ADDR_BUS_ADDR  = 8'ha2;
  localparam logic [7:0] ADDR_LOOP_CFG  = 8'had;
  localparam logic [7:0] ADDR_FAST_SLEW = 8'haf;
  localparam logic [7:0] ADDR_TRANS_OFS = 8'hb0;
  localparam logic [7:0] ADDR_KEY       = 8'hb1;
  localparam logic [7:0] ADDR_SENSE     = 8'hb3;

  // Field positions
  localparam int NOC_TON_BIT  = 5;
  localparam int OFS_DOWN_LSB = 2;
  localparam int OFS_UP_LSB   = 0;

  // Reset and restore defaults (stand-ins for stored user defaults)
  localparam logic [2:0] RST_FAST_SLEW = 3'h0;
  localparam logic [3:0] RST_TRANS_OFS = 4'h0;
  localparam logic [2:0] RST_SENSE     = 3'h0;
  localparam logic       RST_NOC_TON   = 1'b0;
  localparam logic [6:0] RST_BUS_ADDR  = 7'h20;
  localparam logic [7:0] KEY_READBACK  = 8'h00;

  // Negative-overcurrent on-time numerators, mV
  localparam logic [11:0] TON_SHORT_5MV  = 12'h258;
  localparam logic [11:0] TON_LONG_5MV   = 12'h640;
  localparam logic [11:0] TON_SHORT_10MV = 12'h4b0;
  localparam logic [11:0] TON_LONG_10MV  = 12'hc80;

  // VID step sizes, mV
  localparam logic [11:0] STEP_5MV  = 12'h005;
  localparam logic [11:0] STEP_10MV = 12'h00a;

  // Transition offsets, mV
  localparam logic [11:0] OFS_DOWN_MV [0:3] = '{12'h000, 12'h005, 12'h00a, 12'h014};
  localparam logic [11:0] OFS_UP_MV   [0:3] = '{12'h000, 12'h000, 12'h00a, 12'h014};

  // Fast slew rates for 5 mV step, centi-mV/us
  localparam logic [15:0] RATE_5MV_CENTI [0:7] = '{16'h0086, 16'h008f, 16'h00fa, 16'h010b,
                                                    16'h01f4, 16'h022c, 16'h03e8, 16'h04e2};
  // 10 mV step table; code 0 is not an exact double of the 5 mV entry
  localparam logic [15:0] RATE_10MV_CENTI [0:7] = '{16'h010b, 16'h011e, 16'h01f4, 16'h0216,
                                                     16'h03e8, 16'h0458, 16'h07d0, 16'h09c4};

  // Step period in cycles: step over rate; identical for both step sizes
  localparam int CLK_MHZ = 100;
  function automatic logic [11:0] step_period(input int rateCenti);
    return 12'((5 * 100 * CLK_MHZ) / rateCenti);
  endfunction : step_period
  localparam logic [11:0] SLEW_PERIOD [0:7] = '{
    step_period(134), step_period(143), step_period(250), step_period(267),
    step_period(500), step_period(556), step_period(1000), step_period(1250)};
  localparam int QUARTER_SHIFT = 2;

  // Input sense resistor table
  localparam logic [11:0] SENSE_RES_UOHM [0:7] = '{12'hfa0, 12'hbb8, 12'h7d0, 12'h3e8,
                                                    12'h3e8, 12'h1f4, 12'h1f4, 12'h0fa};
  localparam logic [8:0]  SENSE_GAIN_X10 [0:7] = '{9'h07d, 9'h07d, 9'h0fa, 9'h0c8,
                                                    9'h0fa, 9'h190, 9'h1f4, 9'h1f4};
  localparam logic [9:0]  SENSE_IMAX_X10 [0:7] = '{10'h0a0, 10'h0d5, 10'h0a0, 10'h190,
                                                    10'h140, 10'h190, 10'h140, 10'h280};

  typedef enum logic [1:0] {CMD_FAST, CMD_SLOW, CMD_DECAY, CMD_VOUT_I2C} vso_cmd_e;

endpackage : vso_pkg

// ### hw/vso_ramp_if.sv
// Carrier between the configuration bank and its DAC ramp engine.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface vso_ramp_if;
  logic        start;
  logic [11:0] targetMv;
  logic [11:0] stepMv;
  logic [11:0] periodCyc;
  logic [11:0] upOfsMv;
  logic [11:0] downOfsMv;
  logic        ofsEnable;
  logic [11:0] dacMv;
  logic        busy;
  modport ctrl (output start, targetMv, stepMv, periodCyc, upOfsMv, downOfsMv, ofsEnable,
                input dacMv, busy);
  modport eng  (input start, targetMv, stepMv, periodCyc, upOfsMv, downOfsMv, ofsEnable,
                output dacMv, busy);
endinterface : vso_ramp_if

// ### hw/vso_dac_ramp.sv
// DAC ramp engine: steps the target DAC toward a new VID with offsets.
// Assumes start is a one-cycle pulse with the other fields valid with it.
`timescale 1ns/10ps
module vso_dac_ramp (
  input  wire logic clock,
  input  wire logic arst_n,
  vso_ramp_if.eng   rif
);
  typedef enum logic [1:0] {RAMP_IDLE, RAMP_UP, RAMP_DOWN} vso_ramp_e;

  vso_ramp_e   state_reg;
  logic [11:0] count_reg;
  logic [11:0] tgt_reg;
  logic [11:0] step_reg;
  logic [11:0] per_reg;
  logic [11:0] upOfs_reg;
  logic [11:0] thr_reg;
  logic [11:0] tick_reg;
  logic        ofsOn_reg;

  wire logic [11:0] outMv    = count_reg + (ofsOn_reg ? upOfs_reg : 12'h000);
  wire logic        slowZone = (state_reg == RAMP_DOWN) && (count_reg <= thr_reg);
  wire logic [11:0] curPer   = slowZone ? 12'(per_reg << vso_pkg::QUARTER_SHIFT) : per_reg;
  wire logic        tick     = (tick_reg + 12'h001 >= curPer);
  wire logic        goUp     = rif.targetMv > outMv;
  wire logic        goDown   = rif.targetMv < outMv;
  wire logic        upDone   = (count_reg + step_reg + upOfs_reg) >= tgt_reg;
  wire logic        downDone = count_reg <= (tgt_reg + step_reg);

  assign rif.dacMv = outMv;
  assign rif.busy  = (state_reg != RAMP_IDLE);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= RAMP_IDLE;
      count_reg <= 12'h000;
      tgt_reg   <= 12'h000;
      step_reg  <= 12'h000;
      per_reg   <= 12'h000;
      upOfs_reg <= 12'h000;
      thr_reg   <= 12'h000;
      tick_reg  <= 12'h000;
      ofsOn_reg <= 1'b0;
    end else if (rif.start) begin
      // A new command overrides a ramp in flight from the present output
      count_reg <= outMv;
      tgt_reg   <= rif.targetMv;
      step_reg  <= rif.stepMv;
      per_reg   <= rif.periodCyc;
      upOfs_reg <= rif.ofsEnable ? rif.upOfsMv : 12'h000;
      ofsOn_reg <= rif.ofsEnable && goUp; // R11
      thr_reg   <= rif.targetMv + (rif.ofsEnable ? rif.downOfsMv : 12'h000); // R9
      tick_reg  <= 12'h000;
      state_reg <= goUp ? RAMP_UP : (goDown ? RAMP_DOWN : RAMP_IDLE);
    end else if (state_reg != RAMP_IDLE) begin
      tick_reg <= tick ? 12'h000 : tick_reg + 12'h001;
      if (tick) begin
        unique case (state_reg)
          RAMP_UP: begin
            if (upDone) begin
              count_reg <= tgt_reg; // R11
              ofsOn_reg <= 1'b0;
              state_reg <= RAMP_IDLE;
            end else begin
              count_reg <= count_reg + step_reg;
            end
          end
          RAMP_DOWN: begin
            if (downDone) begin
              count_reg <= tgt_reg;
              state_reg <= RAMP_IDLE;
            end else begin
              count_reg <= count_reg - step_reg; // R9
            end
          end
          RAMP_IDLE: begin
            count_reg <= count_reg;
          end
        endcase
      end
    end
  end

  ofs_only_up_a: assert property (@(posedge clock) disable iff (!arst_n) // R11
    ofsOn_reg |-> state_reg == RAMP_UP)
    else $error("Up offset held outside an upward ramp");
  down_no_under_a: assert property (@(posedge clock) disable iff (!arst_n) // R9
    (state_reg == RAMP_DOWN && !rif.start) |=> (count_reg >= tgt_reg || rif.start || $past(rif.start)))
    else $error("Downward ramp went below its target");
  cv_quarter_zone: cover property (@(posedge clock) disable iff (!arst_n)
    slowZone && tick && !downDone);
endmodule : vso_dac_ramp

// ### bench/vso_host_model.sv
// Host model: serial configuration master issuing single-byte requests.
// Assumes the bank takes a request on the rising edge with the strobe high.
`timescale 1ns/10ps
module vso_host_model (
  input  wire logic       clock,
  output logic            wrStb,
  output logic            rdStb,
  output logic [7:0]      addr,
  output logic [7:0]      wrData
);
  initial begin
    wrStb  = 1'b0;
    rdStb  = 1'b0;
    addr   = 8'h00;
    wrData = 8'h00;
  end

  // Released lines show the inverse, so stale values cannot match by luck
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    wrStb  = wr;
    rdStb  = !wr;
    addr   = a;
    wrData = d;
    @(negedge clock);
    wrStb  = 1'b0;
    rdStb  = 1'b0;
    addr   = ~a;
    wrData = ~d;
  endtask : access
endmodule : vso_host_model

// ### bench/tb_top.sv
// Testbench for the configuration bank: lock, registers, tables, VID ramps.
// Assumes answers come one cycle after each strobe, in request order.
`timescale 1ns/10ps
module tb_top;
  localparam logic [15:0] KEY = 16'h5aa5;
  localparam logic [15:0] RATE [0:7] = '{16'h0086, 16'h008f, 16'h00fa, 16'h010b,
                                         16'h01f4, 16'h022c, 16'h03e8, 16'h04e2};
  localparam logic [15:0] RES [0:7] = '{16'h0fa0, 16'h0bb8, 16'h07d0, 16'h03e8,
                                        16'h03e8, 16'h01f4, 16'h01f4, 16'h00fa};
  localparam logic [15:0] GAIN [0:7] = '{16'h007d, 16'h007d, 16'h00fa, 16'h00c8,
                                         16'h00fa, 16'h0190, 16'h01f4, 16'h01f4};
  localparam logic [15:0] IMAX [0:7] = '{16'h00a0, 16'h00d5, 16'h00a0, 16'h0190,
                                         16'h0140, 16'h0190, 16'h0140, 16'h0280};
  logic clock = 1'b0;
  logic arst_n, restoreDefaults, vidCmdStb, softRampActive, wrStb, rdStb;
  logic [1:0] vidStepProtocol;
  logic [7:0] addr, wrData, ansRdData;
  logic [11:0] vidTargetMv, onTime, resUohm, dacMv;
  logic [15:0] fastRateCenti;
  logic [2:0] vidFastRateReg;
  logic ansValid, ansAck, writeUnlocked, rampBusy;
  logic [8:0] gain;
  logic [9:0] imax;
  vso_pkg::vso_cmd_e vidCmdKind;
  logic [8:0] q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  int seed;
  logic [31:0] r;

  always #5 clock = ~clock;

  vso_host_model host (.clock(clock), .wrStb(wrStb), .rdStb(rdStb), .addr(addr),
                       .wrData(wrData));
  vso_config_bank #(.PASS_LEN(2), .PASSCODE(KEY)) uut (
    .clock(clock), .arst_n(arst_n), .cmdWrStb(wrStb), .cmdRdStb(rdStb), .cmdAddr(addr),
    .cmdWrData(wrData), .restoreDefaults(restoreDefaults), .vidStepProtocol(vidStepProtocol),
    .vidCmdStb(vidCmdStb), .vidCmdKind(vidCmdKind), .vidTargetMv(vidTargetMv),
    .softRampActive(softRampActive), .ansValid(ansValid), .ansAck(ansAck),
    .ansRdData(ansRdData), .writeUnlocked(writeUnlocked), .vidFastRateReg(vidFastRateReg),
    .fastRateCenti(fastRateCenti), .negCurrentOnTimeMv(onTime), .senseResMicroOhm(resUohm),
    .senseGainX10(gain), .senseIinMaxX10(imax), .dacMv(dacMv), .rampBusy(rampBusy));

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ack);
    q.push_back({ack, 8'h00});
    host.access(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    q.push_back({1'b1, exp});
    host.access(1'b0, a, 8'h00);
  endtask : rd

  task automatic vid(input vso_pkg::vso_cmd_e k, input logic [11:0] t, input logic s,
                     input logic [11:0] first);
    int n;
    @(negedge clock);
    vidCmdStb = 1'b1;
    vidCmdKind = k;
    vidTargetMv = t;
    softRampActive = s;
    @(negedge clock);
    vidCmdStb = 1'b0;
    vidTargetMv = ~t;
    repeat (2) @(negedge clock);
    check({15'h0, rampBusy}, 16'h0001);
    check({4'h0, dacMv}, {4'h0, first});
    for (n = 0; n < 3000 && rampBusy !== 1'b0; n++) @(negedge clock);
    check({4'h0, dacMv}, {4'h0, t});
    softRampActive = 1'b0;
  endtask : vid

  // Answers are matched strictly in request order
  always @(negedge clock) begin
    if (ansValid === 1'b1) begin
      if (q.size() == 0)
        check({7'h0, ansAck, ansRdData}, 16'hffff);
      else
        check({7'h0, ansAck, ansRdData}, {7'h0, q.pop_front()});
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      error_cnt++;
      test_done();
    end
  end

  initial begin
    seed = 32'hf550;
    {arst_n, restoreDefaults, vidCmdStb, softRampActive} = 4'h0;
    vidStepProtocol = 2'b01;
    vidCmdKind = vso_pkg::CMD_FAST;
    vidTargetMv = 12'h000;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    wr(8'haf, 8'h05, 1'b0);
    wr(8'hb0, 8'h0f, 1'b0);
    rd(8'haf, 8'h00);
    wr(8'h03, 8'h00, 1'b1);
    wr(8'h7a, 8'h01, 1'b1);
    wr(8'h80, 8'h01, 1'b1);
    wr(8'ha2, 8'hff, 1'b1);
    rd(8'ha2, 8'h7f);
    rd(8'hb1, 8'h00);
    wr(8'hb1, KEY[15:8], 1'b0);
    wr(8'hb1, 8'h00, 1'b0);
    wr(8'hb1, KEY[7:0], 1'b0);
    check({15'h0, writeUnlocked}, 16'h0000);
    wr(8'hb1, KEY[15:8], 1'b0);
    wr(8'hb1, KEY[7:0], 1'b0);
    @(negedge clock);
    check({15'h0, writeUnlocked}, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      wr(8'haf, {r[7:3], 3'(i)}, 1'b1);
      check({13'h0, vidFastRateReg}, 16'(i));
      rd(8'haf, 8'(i));
      check(fastRateCenti, RATE[i]);
      wr(8'hb3, {r[15:11], 3'(i)}, 1'b1);
      rd(8'hb3, 8'(i));
      check({4'h0, resUohm}, RES[i]);
      check({7'h0, gain}, GAIN[i]);
      check({6'h0, imax}, IMAX[i]);
    end
    vidStepProtocol = 2'b11;
    repeat (2) @(negedge clock);
    check(fastRateCenti, 16'h09c4);
    for (int j = 0; j < 4; j++) begin
      vidStepProtocol = 2'(j);
      wr(8'had, 8'h20, 1'b1);
      repeat (2) @(negedge clock);
      check({4'h0, onTime}, (j == 1 || j == 2) ? 16'h0258 : 16'h04b0);
      wr(8'had, 8'h00, 1'b1);
      repeat (2) @(negedge clock);
      check({4'h0, onTime}, (j == 1 || j == 2) ? 16'h0640 : 16'h0c80);
    end
    vidStepProtocol = 2'b01;
    wr(8'haf, 8'h07, 1'b1);
    wr(8'hb0, {r[23:20], 4'ha}, 1'b1);
    rd(8'hb0, 8'h0a);
    vid(vso_pkg::CMD_FAST, 12'd40, 1'b0, 12'd10);
    vid(vso_pkg::CMD_DECAY, 12'd60, 1'b0, 12'd40);
    vid(vso_pkg::CMD_SLOW, 12'd80, 1'b1, 12'd60);
    vid(vso_pkg::CMD_SLOW, 12'd100, 1'b0, 12'd90);
    vid(vso_pkg::CMD_VOUT_I2C, 12'd120, 1'b0, 12'd100);
    vid(vso_pkg::CMD_FAST, 12'd40, 1'b0, 12'd120);
    vidStepProtocol = 2'b00;
    restoreDefaults = 1'b1;
    @(negedge clock);
    restoreDefaults = 1'b0;
    repeat (2) @(negedge clock);
    check({15'h0, writeUnlocked}, 16'h0001);
    check(fastRateCenti, 16'h010b);
    rd(8'haf, 8'h00);
    wr(8'hb1, KEY[15:8], 1'b0);
    @(negedge clock);
    check({15'h0, writeUnlocked}, 16'h0000);
    wr(8'haf, 8'h01, 1'b0);
    wr(8'hb1, KEY[15:8], 1'b0);
    wr(8'hb1, KEY[7:0], 1'b0);
    arst_n = 1'b0;
    repeat (2) @(negedge clock);
    arst_n = 1'b1;
    @(negedge clock);
    check({15'h0, writeUnlocked}, 16'h0000);
    wr(8'haf, 8'h01, 1'b0);
    repeat (2) @(negedge clock);
    check(16'(q.size()), 16'h0000);
    test_done();
  end
endmodule : tb_top
